// File: rpeah_apcm_synth_homing.sv
/*
  Pulse-excitation codec datapath: encoder APCM quantizer, decoder inverse
  quantizer, grid upsampler, lattice synthesis, de-emphasis and homing.
  Assumes synchronous inputs; LAR decoding and long-term filtering live
  outside and supply coefficients and residual samples.
*/
// Function
// - Encoder finds 13-sample maximum, 6-bit code
// - Max code intervals log, upper bound decoded
// - Normalize by decoded maximum, not raw
// - Normalized sample maps to 3-bit uniform code
// - Pulse level is -28672 plus 8192*code
// - Inverse quantize then scale by decoded maximum
// - Upsample by three at grid offset
// - Residual goes through long-term synthesis outside
// - Coefficients from LAR codes like encoder
// - Eight-stage lattice synthesis filter
// - De-emphasis adds 28180/32768 of previous output
// - Homing support optional, included here
// - Homing reset only after frame processed
// - Encoder homing frame is 160 samples 0008
// - Decoder emits encoder homing frame when repeated
// - Encoder at home yields decoder homing frame
// - Homing LAR codes fixed eight values
// - Homing subframe codes fixed, one pulse 3
// - Homed decoder replaces output then resets
// - Home state clears lattice, LARs, memories, lag 40
// - Encoder resets state after homing frame
// - Use only valid sample and parameter bits
`timescale 1ns/10ps
module rpeah_apcm_synth_homing #(
  parameter int W = 16
) (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // Encoder pulse input: one selected sample per strobe, 13 per sequence
  input  wire logic                     encValid,
  input  wire logic [15:0]              encSample,
  output logic                          encCodeValid,
  output logic [5:0]                    encBlockMaxCode,
  output logic [38:0]                   encPulseCodes,
  // Encoder homing frame observer: 13-bit left-justified input speech
  input  wire logic                     spValid,
  input  wire logic [15:0]              spSample,
  output logic                          encHomeReset,
  // Decoder parameter input
  input  wire logic                     larValid,
  input  wire logic [47:0]              larCode,
  input  wire logic [8*16-1:0]          reflCoef,
  input  wire logic                     subValid,
  input  wire rpeah_pkg::rpeah_sub_s    subParams,
  input  wire logic [38:0]              pulseCode,
  output logic                          excValid,
  output logic [15:0]                   excSample,
  // Reconstructed short-term residual from long-term synthesis
  input  wire logic                     resValid,
  input  wire logic [15:0]              resSample,
  output logic                          outValid,
  output logic [15:0]                   outSample,
  output logic                          decHomeReset,
  output logic [6:0]                    prevLag
);
  import rpeah_pkg::*;

  // ==========================================================================
  // Helpers
  // Decoded block maximum: upper bound of the code's interval
  function automatic logic [15:0] decodeMax(input logic [5:0] c);
    logic [2:0]  exp;
    logic [15:0] base;
    exp  = (c < 6'd16) ? 3'd0 : 3'(c[5:3] - 3'd1);
    base = (c < 6'd16) ? 16'(c) << 5 : (16'd256 << exp) + (16'(c[2:0]) << (4'(exp) + 4'd5));
    decodeMax = base + ((16'd32 << exp) - 16'd1);
  endfunction : decodeMax

  // Smallest code whose decoded bound covers the magnitude
  function automatic logic [5:0] encodeMax(input logic [15:0] m);
    logic [5:0] c;
    c = 6'd63;
    for (int i = 62; i >= 0; i--) begin
      if (m <= decodeMax(6'(i))) begin
        c = 6'(i);
      end
    end
    encodeMax = c;
  endfunction : encodeMax

  // Q15 saturating multiply
  function automatic logic [15:0] mulQ15(input logic [15:0] a, input logic [15:0] b);
    logic signed [31:0] p;
    p = (32'(signed'(a)) * 32'(signed'(b))) >>> 15;
    if (p > 32'sd32767) p = 32'sd32767;
    if (p < -32'sd32768) p = -32'sd32768;
    mulQ15 = p[15:0];
  endfunction : mulQ15
  function automatic logic [15:0] satAdd(input logic [15:0] a, input logic [15:0] b);
    logic signed [16:0] s;
    s = 17'(signed'(a)) + 17'(signed'(b));
    if (s > 17'sd32767) s = 17'sd32767;
    if (s < -17'sd32768) s = -17'sd32768;
    satAdd = s[15:0];
  endfunction : satAdd

  // ==========================================================================
  // Encoder APCM: collect 13 samples, then quantize
  logic [15:0] encBuf [PULSES];
  logic [3:0]  encCnt, next_encCnt;
  logic        encFull, next_encFull;
  logic [5:0]  qCode;
  logic [15:0] qMax;
  logic [38:0] qPulses;

  always_comb begin
    logic [15:0] mag;
    logic [15:0] peak;
    logic signed [31:0] norm;
    logic signed [31:0] idx;
    mag  = 16'h0000;
    peak = 16'h0000;
    norm = 32'sd0;
    idx  = 32'sd0;
    for (int i = 0; i < PULSES; i++) begin
      mag = encBuf[i][15] ? 16'(-encBuf[i]) : encBuf[i];
      if (encBuf[i] == 16'h8000) mag = MAX_TOP;
      if (mag > peak) peak = mag;
    end
    qCode = encodeMax(peak);
    qMax  = decodeMax(qCode);
    qPulses = '0;
    for (int i = 0; i < PULSES; i++) begin
      norm = (32'(signed'(encBuf[i])) <<< 15) / 32'(signed'(qMax));
      idx  = (norm + 32'sd32768) >>> 13;
      if (idx > 32'sd7) idx = 32'sd7;
      if (idx < 32'sd0) idx = 32'sd0;
      qPulses[3*i +: 3] = idx[2:0];
    end
    next_encCnt  = encCnt;
    next_encFull = 1'b0;
    if (encValid) begin
      next_encFull = (encCnt == 4'(PULSES - 1));
      next_encCnt  = next_encFull ? 4'h0 : encCnt + 4'h1;
    end
  end

  // Registers the collection buffer and codes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      encCnt          <= 4'h0;
      encFull         <= 1'b0;
      encCodeValid    <= 1'b0;
      encBlockMaxCode <= 6'h00;
      encPulseCodes   <= '0;
      for (int i = 0; i < PULSES; i++) encBuf[i] <= 16'h0000;
    end else begin
      encCnt       <= next_encCnt;
      encFull      <= next_encFull;
      encCodeValid <= encFull;
      if (encValid) encBuf[encCnt] <= encSample;
      if (encFull) begin
        encBlockMaxCode <= qCode;
        encPulseCodes   <= qPulses;
      end
    end
  end

  // ==========================================================================
  // Encoder homing frame detection over 160 aligned input samples
  logic [7:0] spCnt, next_spCnt;
  logic       spAllHome, next_spAllHome;
  logic       next_encHomeReset;

  always_comb begin
    logic lastS;
    lastS          = (spCnt == 8'(FRAME_LEN - 1));
    next_spCnt     = spCnt;
    next_spAllHome = spAllHome;
    next_encHomeReset = 1'b0;
    if (spValid) begin
      next_spCnt     = lastS ? 8'h00 : spCnt + 8'h01;
      // Only the upper 13 bits carry the sample
      next_spAllHome = lastS ? 1'b1 : spAllHome & (spSample[15:3] == ENC_HOME_SAMPLE[15:3]);
      next_encHomeReset = lastS & spAllHome & (spSample[15:3] == ENC_HOME_SAMPLE[15:3]);
    end
  end

  // Registers the encoder homing tracker
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      spCnt        <= 8'h00;
      spAllHome    <= 1'b1;
      encHomeReset <= 1'b0;
    end else begin
      spCnt        <= next_spCnt;
      spAllHome    <= next_spAllHome;
      encHomeReset <= next_encHomeReset;
    end
  end

  // ==========================================================================
  // Decoder inverse quantizer and grid upsampler
  logic [1:0]  subIdx, next_subIdx;
  logic [5:0]  upCnt, next_upCnt;
  logic        upRun, next_upRun;
  logic [38:0] pulseHold;
  rpeah_sub_s  subHold;
  logic        next_excValid;
  logic [15:0] next_excSample;

  always_comb begin
    logic [3:0]  slot;
    logic [15:0] lvl;
    slot = 4'((upCnt - 6'(subHold.gridPositionCode)) / UPSAMPLE);
    lvl  = LEVEL_ZERO + 16'(pulseHold[3*slot +: 3]) * STEP_LEVEL;
    next_upCnt     = upCnt;
    next_upRun     = upRun;
    next_excValid  = 1'b0;
    next_excSample = 16'h0000;
    if (subValid) begin
      next_upRun = 1'b1;
      next_upCnt = 6'h00;
    end else if (upRun) begin
      next_excValid = 1'b1;
      // Pulse only where the phase matches the grid offset
      if (upCnt >= 6'(subHold.gridPositionCode) && slot < 4'(PULSES) &&
          6'((upCnt - 6'(subHold.gridPositionCode)) % UPSAMPLE) == 6'h00)
        next_excSample = mulQ15(lvl, decodeMax(subHold.blockMaxCode));
      next_upCnt = upCnt + 6'h01;
      next_upRun = (upCnt != 6'd39);
    end
    next_subIdx = subValid ? subIdx + 2'h1 : subIdx;
  end

  // Registers the upsampler
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      subIdx    <= 2'h0;
      upCnt     <= 6'h00;
      upRun     <= 1'b0;
      pulseHold <= '0;
      subHold   <= '0;
      excValid  <= 1'b0;
      excSample <= 16'h0000;
    end else begin
      subIdx    <= larValid ? 2'h0 : next_subIdx;
      upCnt     <= next_upCnt;
      upRun     <= next_upRun;
      excValid  <= next_excValid;
      excSample <= next_excSample;
      if (subValid) begin
        pulseHold <= pulseCode;
        subHold   <= subParams;
      end
    end
  end

  // ==========================================================================
  // Decoder homing frame detection and home state
  logic       frmHome, next_frmHome;
  logic       atHome, next_atHome;
  logic       replaceOut, next_replaceOut;
  logic [7:0] outCnt, next_outCnt;
  logic       homeNow;
  always_comb begin
    logic subOk;
    subOk = (subParams.lagCode == HOME_LAG) && subParams.gainCode == 2'h0 &&
            subParams.gridPositionCode == 2'h0 && subParams.blockMaxCode == 6'h00;
    for (int i = 0; i < PULSES; i++) begin
      if (subIdx == 2'(ODD_SUBFRAME) && i == ODD_PULSE) subOk = subOk & (pulseCode[3*i +: 3] == HOME_PULSE_ODD);
      else subOk = subOk & (pulseCode[3*i +: 3] == HOME_PULSE);
    end
    next_frmHome = frmHome;
    if (larValid) next_frmHome = (larCode == HOME_LARS);
    if (subValid) next_frmHome = next_frmHome & subOk;
    homeNow = resValid && outCnt == 8'(FRAME_LEN - 1) && frmHome;
    next_atHome = atHome;
    next_replaceOut = replaceOut;
    next_outCnt = resValid ? ((outCnt == 8'(FRAME_LEN - 1)) ? 8'h00 : outCnt + 8'h01) : outCnt;
    if (resValid && outCnt == 8'(FRAME_LEN - 1)) begin
      next_atHome     = frmHome;
      next_replaceOut = 1'b0;
    end
    if (larValid) next_replaceOut = atHome && (larCode == HOME_LARS);
  end

  // ==========================================================================
  // Lattice synthesis and de-emphasis
  logic [15:0] vState [LAR_COUNT + 1];
  logic [15:0] deemMem;
  logic [15:0] synthOut;
  logic [15:0] vNext [LAR_COUNT + 1];

  always_comb begin
    logic [15:0] s;
    s = resSample;
    for (int i = 1; i <= LAR_COUNT; i++) begin
      // Coefficient r(9-i) sits at lane 8-i
      s = satAdd(s, 16'(-mulQ15(reflCoef[16*(LAR_COUNT - i) +: 16], vState[LAR_COUNT - i])));
      vNext[9 - i] = satAdd(vState[LAR_COUNT - i], mulQ15(reflCoef[16*(LAR_COUNT - i) +: 16], s));
    end
    vNext[0] = s;
    synthOut = satAdd(s, mulQ15(DEEMPH_COEF, deemMem));
  end

  // Registers filter memories, output and homing state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i <= LAR_COUNT; i++) vState[i] <= 16'h0000;
      deemMem      <= 16'h0000;
      outValid     <= 1'b0;
      outSample    <= 16'h0000;
      frmHome      <= 1'b0;
      atHome       <= 1'b1;
      replaceOut   <= 1'b0;
      outCnt       <= 8'h00;
      decHomeReset <= 1'b0;
      prevLag      <= HOME_LAG;
    end else begin
      frmHome      <= next_frmHome;
      atHome       <= next_atHome;
      replaceOut   <= next_replaceOut;
      outCnt       <= next_outCnt;
      outValid     <= resValid;
      decHomeReset <= homeNow;
      if (subValid) prevLag <= subParams.lagCode;
      if (resValid) begin
        // Upper 13 bits only leave the block
        outSample <= replaceOut ? ENC_HOME_SAMPLE : {synthOut[15:3], 3'b000};
        for (int i = 0; i <= LAR_COUNT; i++) vState[i] <= vNext[i];
        deemMem <= synthOut;
      end
      if (homeNow) begin
        for (int i = 0; i <= LAR_COUNT; i++) vState[i] <= 16'h0000;
        deemMem <= 16'h0000;
        prevLag <= HOME_LAG;
      end
    end
  end

  // ==========================================================================
  // Checks
  chk_max_decode: assert property (@(posedge clk) disable iff (!resetn)
    encCodeValid |-> decodeMax(encBlockMaxCode) != 16'h0000)
    else $error("decoded maximum zero");
  chk_home_lag: assert property (@(posedge clk) disable iff (!resetn)
    decHomeReset |-> prevLag == HOME_LAG)
    else $error("lag not home after homing");
  chk_home_out: assert property (@(posedge clk) disable iff (!resetn)
    (resValid && replaceOut) |=> outSample == ENC_HOME_SAMPLE)
    else $error("homing output not substituted");
  chk_home_end: assert property (@(posedge clk) disable iff (!resetn)
    decHomeReset |-> $past(outCnt) == 8'(FRAME_LEN - 1))
    else $error("homing reset mid-frame");
  chk_mem_clear: assert property (@(posedge clk) disable iff (!resetn)
    decHomeReset |-> deemMem == 16'h0000)
    else $error("de-emphasis not cleared");
  chk_enc_code: assert property (@(posedge clk) disable iff (!resetn)
    encFull |=> encCodeValid ##1 !encCodeValid)
    else $error("encoder code strobe wrong");
  chk_exc_len: assert property (@(posedge clk) disable iff (!resetn)
    subValid |=> ##1 excValid [*8])
    else $error("excitation burst short");
  chk_enc_home: assert property (@(posedge clk) disable iff (!resetn)
    encHomeReset |-> $past(spValid) && $past(spCnt) == 8'(FRAME_LEN - 1))
    else $error("encoder homing misaligned");
  chk_out_bits: assert property (@(posedge clk) disable iff (!resetn)
    outValid |-> outSample[2:0] == 3'b000)
    else $error("invalid output bits");
endmodule : rpeah_apcm_synth_homing

// File: rpeah_pkg.sv
/*
  Package for the pulse-excitation codec datapath and homing logic.
  Holds constants, enumerations and carrier structs shared by the design.
  Assumes a single 50 MHz clock and an active-low asynchronous reset.
*/
package rpeah_pkg;
  // ==========================================================================
  // Frame geometry
  localparam int PULSES     = 13;
  localparam int SUBFRAMES  = 4;
  localparam int FRAME_LEN  = 160;
  localparam int LAR_COUNT  = 8;
  localparam int UPSAMPLE   = 3;
  // ==========================================================================
  // Quantizer constants
  localparam logic [15:0] STEP_LEVEL   = 16'h2000; // Pulse interval width 8192
  localparam logic [15:0] LEVEL_ZERO   = 16'h9000; // Level of code 0, -28672
  localparam logic [15:0] MAX_LINEAR   = 16'h01FF; // Last linear interval end 511
  localparam logic [15:0] MAX_TOP      = 16'h7FFF; // Last interval end 32767
  localparam logic [15:0] DEEMPH_COEF  = 16'h6E14; // 28180
  // ==========================================================================
  // Homing constants
  localparam logic [15:0] ENC_HOME_SAMPLE = 16'h0008;
  localparam logic [6:0]  HOME_LAG        = 7'h28;
  localparam logic [2:0]  HOME_PULSE      = 3'h4;
  localparam logic [2:0]  HOME_PULSE_ODD  = 3'h3;
  localparam int          ODD_SUBFRAME    = 3;
  localparam int          ODD_PULSE       = 4;
  localparam logic [47:0] HOME_LARS = {6'h02, 6'h03, 6'h03, 6'h07, 6'h08, 6'h0F, 6'h17, 6'h09};
  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic [6:0] lagCode;
    logic [1:0] gainCode;
    logic [1:0] gridPositionCode;
    logic [5:0] blockMaxCode;
  } rpeah_sub_s;

  typedef struct packed {
    logic             valid;
    logic [2:0]       code;
  } rpeah_pulse_s;

  typedef enum logic [2:0] {DS_IDLE, DS_PULSE, DS_SYNTH, DS_OUT} rpeah_dstate_e;
endpackage : rpeah_pkg

// File: rpeah_far_end.sv
/*
  Far-end speech source for the codec datapath bench: sends aligned frames.
  Assumes the bench raises sendReq for one clock and holds the words steady.
*/
`timescale 1ns/10ps
module rpeah_far_end (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        sendReq,
  input  wire logic [15:0] sendWord,
  input  wire logic [15:0] oddWord,
  output logic             spValid,
  output logic [15:0]      spSample
);
  int cnt;
  // ==========================================================================
  // Frame source: 160 samples back to back, first one may differ
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt      <= 0;
      spValid  <= 1'b0;
      spSample <= 16'h5555;
    end else if (sendReq || (cnt != 0)) begin
      spValid  <= 1'b1;
      spSample <= (cnt == 0) ? oddWord : sendWord;
      cnt      <= (cnt == 159) ? 0 : cnt + 1;
    end else begin
      spValid  <= 1'b0;
      spSample <= ~spSample; // Released line toggles
    end
  end
endmodule : rpeah_far_end

// File: tb.sv
/*
  Self-checking bench for the pulse-excitation codec datapath and homing.
  Assumes rpeah_pkg and the far-end speech source model.
*/
`timescale 1ns/10ps
module tb;
  import rpeah_pkg::*;
  logic        clk, resetn, encValid, encCodeValid, spReq, spValid, encHomeReset;
  logic [15:0] encSample, spWord, spOdd, spSample, excSample, resSample, outSample;
  logic [5:0]  encBlockMaxCode;
  logic [38:0] encPulseCodes, pulseCode;
  logic        larValid, subValid, excValid, resValid, outValid, decHomeReset;
  logic [47:0] larCode;
  logic [127:0] reflCoef;
  rpeah_sub_s  subParams;
  logic [6:0]  prevLag;
  logic [15:0] outs[160];
  int          err_total, compares;
  // ==========================================================================
  // Clock and units
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  rpeah_apcm_synth_homing u_dut (.clk(clk), .resetn(resetn), .encValid(encValid), .encSample(encSample),
    .encCodeValid(encCodeValid), .encBlockMaxCode(encBlockMaxCode), .encPulseCodes(encPulseCodes),
    .spValid(spValid), .spSample(spSample), .encHomeReset(encHomeReset), .larValid(larValid),
    .larCode(larCode), .reflCoef(reflCoef), .subValid(subValid), .subParams(subParams),
    .pulseCode(pulseCode), .excValid(excValid), .excSample(excSample), .resValid(resValid),
    .resSample(resSample), .outValid(outValid), .outSample(outSample), .decHomeReset(decHomeReset),
    .prevLag(prevLag));
  rpeah_far_end u_far (.clk(clk), .resetn(resetn), .sendReq(spReq), .sendWord(spWord),
    .oddWord(spOdd), .spValid(spValid), .spSample(spSample));
  // ==========================================================================
  // Reporting and comparison
  task automatic final_report();
    $display("compares=%0d errors=%0d", compares, err_total);
    if ((err_total == 0) && (compares > 0)) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_near(input logic [15:0] got, input int exp, input int tol);
    int g;
    g = int'($signed(got));
    compares++;
    if ((^got === 1'bx) || (g - exp > tol) || (exp - g > tol)) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp[15:0]);
    end
  endtask : chk_near
  task automatic hang_stop();
    err_total++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    final_report();
  endtask : hang_stop
  // ==========================================================================
  // Expected values of the quantizers
  function automatic int dec_max(input int c);
    if (c < 16) return 32 * c + 31;
    return (512 << ((c - 16) / 8)) + (64 << ((c - 16) / 8)) * ((c - 16) % 8 + 1) - 1;
  endfunction : dec_max
  function automatic int max_code(input int m);
    int c;
    c = 0;
    while (dec_max(c) < m) c++;
    return c;
  endfunction : max_code
  function automatic int pulse_of(input int x, input int d);
    int p;
    p = (x + d) * 4 / d;
    return (p > 7) ? 7 : p;
  endfunction : pulse_of
  // ==========================================================================
  // Stimulus helpers
  task automatic send13(input int v[13]);
    int n;
    for (int i = 0; i < 13; i++) begin
      @(negedge clk);
      encValid  <= 1'b1;
      encSample <= v[i][15:0];
    end
    @(negedge clk);
    encValid <= 1'b0;
    for (n = 0; (n < 8) && (encCodeValid !== 1'b1); n++) @(negedge clk);
    if (encCodeValid !== 1'b1) hang_stop();
  endtask : send13
  task automatic sp_frame(input logic [15:0] w, input logic [15:0] o, input logic exp);
    int n;
    @(negedge clk);
    spWord <= w;
    spOdd  <= o;
    spReq  <= 1'b1;
    @(negedge clk);
    spReq <= 1'b0;
    for (n = 0; (n < 170) && (spValid === 1'b1); n++) @(negedge clk);
    if (spValid !== 1'b0) hang_stop();
    chk(encHomeReset, exp);
    @(negedge clk);
    chk(encHomeReset, 1'b0);
  endtask : sp_frame
  task automatic send_frame(input logic [47:0] lars, input logic [6:0] lag, input logic home);
    int n;
    int lvl;
    @(negedge clk);
    larValid <= 1'b1;
    larCode  <= lars;
    @(negedge clk);
    larValid <= 1'b0;
    for (int j = 0; j < 4; j++) begin
      subParams <= '{lag, 2'h0, home ? 2'h0 : 2'(j), home ? 6'h00 : 6'h3F};
      for (int i = 0; i < 13; i++) begin
        pulseCode[3*i +: 3] <= !home ? 3'(i % 8) :
                               ((j == ODD_SUBFRAME) && (i == ODD_PULSE)) ? HOME_PULSE_ODD : HOME_PULSE;
      end
      subValid <= 1'b1;
      @(negedge clk);
      subValid <= 1'b0;
      for (int k = 0; k < 40; k++) begin
        for (n = 0; (n < 4) && (excValid !== 1'b1); n++) @(negedge clk);
        if (excValid !== 1'b1) hang_stop();
        lvl = (k >= j) && ((k - j) % 3 == 0) && (k - j < 39) ?
              (8192 * ((k - j) / 3 % 8) - 28672) * 32767 / 32768 : 0;
        if (!home) chk_near(excSample, lvl, 1);
        @(negedge clk);
      end
    end
  endtask : send_frame
  task automatic res_frame(input logic homeExp);
    int n;
    for (int k = 0; k < 160; k++) begin
      @(negedge clk);
      resValid  <= 1'b1;
      resSample <= (k == 0) ? 16'h1000 : 16'h0000;
      @(negedge clk);
      resValid <= 1'b0;
      for (n = 0; (n < 4) && (outValid !== 1'b1); n++) @(negedge clk);
      if (outValid !== 1'b1) hang_stop();
      outs[k] = outSample;
      chk(decHomeReset, (k == 159) && homeExp);
    end
  endtask : res_frame
  // ==========================================================================
  // Scenarios
  task automatic test_reset();
    chk({encCodeValid, encHomeReset, excValid, outValid, decHomeReset}, 5'h00);
    chk(prevLag, 7'h28);
    $display("test reset done");
  endtask : test_reset
  task automatic test_enc_quant();
    int v[13] = '{500, 0, -1, -500, 200, 100, 300, -200, -300, 126, 50, -50, 400};
    send13(v);
    chk(encBlockMaxCode, max_code(500));
    for (int i = 0; i < 13; i++) chk(encPulseCodes[3*i +: 3], pulse_of(v[i], dec_max(15)));
    $display("test enc_quant done");
  endtask : test_enc_quant
  task automatic test_enc_max();
    int m[8] = '{31, 32, 511, 512, 2047, 2048, 32767, 1000};
    int v[13];
    for (int k = 0; k < 8; k++) begin
      v = '{default: 0};
      v[k + 2] = (k % 2) ? -m[k] : m[k];
      send13(v);
      chk(encBlockMaxCode, max_code(m[k]));
      chk(encPulseCodes[3*(k+2) +: 3], pulse_of(v[k + 2], dec_max(max_code(m[k]))));
    end
    $display("test enc_max done");
  endtask : test_enc_max
  task automatic test_enc_home();
    sp_frame(16'h000F, 16'h000F, 1'b1);
    sp_frame(16'h000F, 16'h0010, 1'b0);
    sp_frame(ENC_HOME_SAMPLE, ENC_HOME_SAMPLE, 1'b1);
    $display("test enc_home done");
  endtask : test_enc_home
  task automatic test_deemph();
    send_frame(48'h0, 7'h32, 1'b0);
    res_frame(1'b0);
    chk_near(outs[0], 4096, 0);
    chk_near(outs[1], 3522, 8);
    chk_near(outs[2], 3029, 8);
    // Last stage at one half: impulse alternates through the lattice
    @(negedge clk);
    reflCoef <= 128'h4000;
    res_frame(1'b0);
    chk_near(outs[0], 4096, 0);
    chk_near(outs[1], 1474, 8);
    chk_near(outs[2], 2291, 8);
    @(negedge clk);
    reflCoef <= '0;
    $display("test deemph done");
  endtask : test_deemph
  task automatic test_dec_home();
    send_frame(HOME_LARS, HOME_LAG, 1'b1);
    res_frame(1'b1);
    chk_near(outs[0], 4096, 16);
    chk(prevLag, HOME_LAG);
    send_frame(HOME_LARS, HOME_LAG, 1'b1);
    res_frame(1'b1);
    for (int k = 0; k < 160; k++) chk(outs[k], ENC_HOME_SAMPLE);
    $display("test dec_home done");
  endtask : test_dec_home
  // ==========================================================================
  // Main sequence
  initial begin
    err_total = 0;
    compares  = 0;
    {resetn, encValid, spReq, larValid, subValid, resValid} = 6'h00;
    {encSample, spWord, spOdd, resSample, larCode, pulseCode, reflCoef} = '0;
    subParams = '0;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    test_reset();
    test_enc_quant();
    test_enc_max();
    test_enc_home();
    test_deemph();
    test_dec_home();
    final_report();
  end
endmodule : tb
